// *** rtl/pbs_map.svh ***
// Constants for the pipelined burst SRAM core.
`ifndef PBS_MAP_SVH
`define PBS_MAP_SVH
`define PBS_ADDR_W      17
`define PBS_DATA_W      36
`define PBS_LANES       4
`define PBS_LANE_W      9
`define PBS_DEPTH       131072
`define PBS_BURST_LEN   4
`define PBS_WAKE_CYC    2
`define PBS_SLEEP_CYC   2
`define PBS_OE_CYC      2
`define PBS_FIFO_W      36
`define PBS_FIFO_DEPTH  16
`endif

// *** rtl/pbs_pkg.sv ***
// Types for the pipelined burst SRAM core.
package pbs_pkg;
  typedef enum logic [1:0] {
    PBS_IDLE,
    PBS_READ,
    PBS_WRITE
  } pbs_mode_t;
  typedef enum logic [1:0] {
    PBS_AWAKE,
    PBS_ASLEEP,
    PBS_WAKING
  } pbs_pwr_t;
endpackage

// *** rtl/pbs_core.sv ***
// Pipelined burst SRAM core with write-data FIFO.
`timescale 1ns/100ps
`include "pbs_map.svh"

// Small FIFO with valid and ready on both sides.
module pbs_fifo #(
  parameter int WIDTH = `PBS_FIFO_W,
  parameter int DEPTH = `PBS_FIFO_DEPTH
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // Storage words.
  logic [AW-1:0]    wr_ptr;        // Next slot to fill.
  logic [AW-1:0]    rd_ptr;        // Next slot to drain.
  logic [AW:0]      count;         // Words held.
  logic             push;          // A word enters.
  logic             pop;           // A word leaves.

  assign in_ready_o  = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  // Pointers and occupancy advance on each accepted transfer.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

  // Storage is written without reset.
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

// Burst SRAM control, array and read pipeline.
module pbs_core (
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  input  wire logic [`PBS_ADDR_W-1:0] addr_i,
  input  wire logic                   processor_addr_strobe_n_i,
  input  wire logic                   controller_addr_strobe_n_i,
  input  wire logic                   burst_advance_n_i,
  input  wire logic                   global_write_n_i,
  input  wire logic                   byte_write_enable_n_i,
  input  wire logic                   lane_a_write_n_i,
  input  wire logic                   lane_b_write_n_i,
  input  wire logic                   lane_c_write_n_i,
  input  wire logic                   lane_d_write_n_i,
  input  wire logic                   chip_select_primary_n_i,
  input  wire logic                   chip_select_secondary_i,
  input  wire logic                   chip_select_secondary_n_i,
  input  wire logic                   output_enable_n_i,
  input  wire logic                   burst_order_select_i,
  input  wire logic                   sleep_request_i,
  input  wire logic [`PBS_DATA_W-1:0] dq_i,
  output logic      [`PBS_DATA_W-1:0] dq_o,
  output logic                        dq_oe_o,
  output logic                        wr_fifo_ready_o,
  output logic                        asleep_o
);
  localparam int LW = `PBS_LANE_W;
  localparam int NL = `PBS_LANES;

  // Two-flop synchronisers on the clockless pins.
  logic [2:0] async_meta;             // First stage, read only by second.
  logic [2:0] async_sync;             // Second stage: oe_n, order, sleep.
  logic       oe_n_s;                 // Synchronised output enable, low active.
  logic       order_s;                // Synchronised burst order.
  logic       sleep_s;                // Synchronised sleep request.

  // Sampled control state.
  logic [`PBS_ADDR_W-1:0] base_addr;  // Registered external address.
  logic [1:0]             burst_cnt;  // Internal burst counter.
  pbs_pkg::pbs_mode_t     mode;       // Current burst kind.
  pbs_pkg::pbs_pwr_t      pwr;        // Power state.
  logic [1:0]             pwr_cnt;    // Wake counter, cleared on wake start.
  logic [1:0]             sel_pipe;   // Delayed drive permission.
  logic                   rd_valid1;  // Stage one holds read data.
  logic                   rd_valid2;  // Stage two holds read data.
  logic [`PBS_DATA_W-1:0] rd_stage1;  // Data-out register.

  // Array storage.
  logic [`PBS_DATA_W-1:0] mem [`PBS_DEPTH];

  // Decoded sampled events of this edge.
  logic       awake;                  // Core may act.
  logic       selected;               // All three selects active.
  logic       proc_start;             // Processor strobe starts a read.
  logic       ctrl_start;             // Controller strobe starts a cycle.
  logic [3:0] lanes_n;                // Lane write inputs.
  logic [3:0] lane_we;                // Lanes written this edge.
  logic       any_write;              // Some lane sampled for writing.
  logic [1:0] low_bits;               // Burst-ordered low address bits.
  logic [`PBS_ADDR_W-1:0] cur_addr;   // Address accessed this edge.
  logic [`PBS_ADDR_W-1:0] next_addr;  // Address used for a new start.
  logic [1:0]             step_cnt;   // Burst count after this edge's advance.
  logic [1:0]             wr_low;     // Low address bits written this edge.
  logic                   deselect;   // Strobe taken while not fully selected.

  // FIFO wiring carrying captured write words to the array.
  logic                   wf_valid;
  logic [`PBS_DATA_W-1:0] wf_data;
  logic                   wf_in_ready;
  logic [`PBS_ADDR_W-1:0] wa_q;       // Address of pending write.
  logic [3:0]             wl_q;       // Lanes of pending write.
  logic                   wp_q;       // Pending write flag.

  assign oe_n_s  = async_sync[0];
  assign order_s = async_sync[1];
  assign sleep_s = async_sync[2];

  // Clockless pins pass two flip-flops before use.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      // Sleep resets low in both stages, so no false sleep follows reset.
      async_meta <= 3'h1;
      async_sync <= 3'h1;
    end else begin
      async_meta <= {sleep_request_i, burst_order_select_i, output_enable_n_i};
      async_sync <= async_meta;
    end
  end

  assign awake      = (pwr == pbs_pkg::PBS_AWAKE);
  assign selected   = !chip_select_primary_n_i && chip_select_secondary_i
                      && !chip_select_secondary_n_i;
  assign proc_start = awake && !processor_addr_strobe_n_i && selected;
  assign ctrl_start = awake && !proc_start && !controller_addr_strobe_n_i
                      && processor_addr_strobe_n_i && selected;
  assign lanes_n    = {lane_d_write_n_i, lane_c_write_n_i,
                       lane_b_write_n_i, lane_a_write_n_i};
  // Global write beats byte enables; lane writes unused on processor start.
  assign lane_we    = proc_start ? 4'h0 :
                      !global_write_n_i ? 4'hF :
                      !byte_write_enable_n_i ? ~lanes_n : 4'h0;
  assign any_write  = awake && (lane_we != 4'h0) && (ctrl_start || mode != pbs_pkg::PBS_IDLE);
  // Interleaved order xors the count, linear order adds it.
  assign low_bits   = order_s ? (base_addr[1:0] ^ burst_cnt)
                              : 2'(base_addr[1:0] + burst_cnt);
  assign cur_addr   = {base_addr[`PBS_ADDR_W-1:2], low_bits};
  assign next_addr  = (proc_start || ctrl_start) ? addr_i : cur_addr;
  // A write on an advancing edge after the start lands at the next burst address.
  assign step_cnt   = burst_advance_n_i ? burst_cnt : 2'(burst_cnt + 2'h1);
  assign wr_low     = order_s ? (base_addr[1:0] ^ step_cnt)
                              : 2'(base_addr[1:0] + step_cnt);
  // A controller strobe, or a processor strobe with the primary select low, seen while the selects are not all active ends the burst.
  assign deselect   = awake && !proc_start && !ctrl_start && !selected
                      && (!controller_addr_strobe_n_i
                          || (!processor_addr_strobe_n_i && !chip_select_primary_n_i));

  // Address register and burst counter; advance ignored on processor start.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      base_addr <= '0;
      burst_cnt <= 2'h0;
      mode      <= pbs_pkg::PBS_IDLE;
    end else if (awake) begin
      if (proc_start) begin
        base_addr <= addr_i;
        burst_cnt <= 2'h0;
        mode      <= pbs_pkg::PBS_READ;
      end else if (ctrl_start) begin
        base_addr <= addr_i;
        burst_cnt <= 2'h0;
        mode      <= (lane_we != 4'h0) ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
      end else if (deselect) begin
        mode <= pbs_pkg::PBS_IDLE;
      end else if (mode != pbs_pkg::PBS_IDLE) begin
        mode <= (lane_we != 4'h0) ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
        if (!burst_advance_n_i) begin
          burst_cnt <= 2'(burst_cnt + 2'h1);
        end
      end
    end
  end

  // Captured write word enters the FIFO on the sampling edge.
  assign wf_valid = any_write;

  pbs_fifo #(
    .WIDTH (`PBS_FIFO_W),
    .DEPTH (`PBS_FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (wf_valid),
    .in_ready_o  (wf_in_ready),
    .in_data_i   (dq_i),
    .out_valid_o (),
    .out_ready_i (wp_q),
    .out_data_o  (wf_data)
  );

  assign wr_fifo_ready_o = wf_in_ready;

  // Pending write address and lanes follow the word one edge later.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wa_q <= '0;
      wl_q <= 4'h0;
      wp_q <= 1'b0;
    end else begin
      wp_q <= wf_valid && wf_in_ready;
      wa_q <= ctrl_start ? addr_i : {base_addr[`PBS_ADDR_W-1:2], wr_low};
      wl_q <= lane_we;
    end
  end

  // Each lane writes its eight data bits and parity bit alike.
  always_ff @(posedge sys_clk_i) begin
    if (wp_q) begin
      for (int l = 0; l < NL; l++) begin
        if (wl_q[l]) begin
          mem[wa_q][l*LW +: LW] <= wf_data[l*LW +: LW];
        end
      end
    end
  end

  // Two-stage read pipeline: data-out register then output register.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rd_stage1 <= '0;
      dq_o      <= '0;
      rd_valid1 <= 1'b0;
      rd_valid2 <= 1'b0;
    end else if (awake) begin
      rd_stage1 <= mem[next_addr];
      dq_o      <= rd_stage1;
      rd_valid1 <= (proc_start || mode == pbs_pkg::PBS_READ) && !any_write;
      rd_valid2 <= rd_valid1;
    end
  end

  // Drive permission follows selection with a two-cycle delay.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sel_pipe <= 2'h0;
    end else begin
      sel_pipe <= {sel_pipe[0], proc_start || ctrl_start
                   || (mode != pbs_pkg::PBS_IDLE && !deselect)};
    end
  end

  // Drivers off while writing, asleep or output disabled.
  assign dq_oe_o = awake && sel_pipe[1] && rd_valid2 && !oe_n_s && !any_write;

  // Sleep entry and two-cycle wake; contents are preserved.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pwr     <= pbs_pkg::PBS_AWAKE;
      pwr_cnt <= 2'h0;
    end else begin
      case (pwr)
        pbs_pkg::PBS_AWAKE: begin
          if (sleep_s) begin
            pwr <= pbs_pkg::PBS_ASLEEP;
          end
        end
        pbs_pkg::PBS_ASLEEP: begin
          if (!sleep_s) begin
            pwr     <= pbs_pkg::PBS_WAKING;
            pwr_cnt <= 2'h0;
          end
        end
        pbs_pkg::PBS_WAKING: begin
          if (sleep_s) begin
            pwr <= pbs_pkg::PBS_ASLEEP;
          end else if (pwr_cnt == 2'(`PBS_WAKE_CYC - 1)) begin
            pwr <= pbs_pkg::PBS_AWAKE;
          end else begin
            pwr_cnt <= 2'(pwr_cnt + 2'h1);
          end
        end
        default: begin
          pwr <= pbs_pkg::PBS_AWAKE;
        end
      endcase
    end
  end

  assign asleep_o = (pwr != pbs_pkg::PBS_AWAKE);
endmodule

// *** sim/pbs_core_monitor.sv ***
// Port checker for the burst SRAM core.
`timescale 1ns/100ps
module pbs_core_monitor (
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  input  wire logic processor_addr_strobe_n_i,
  input  wire logic controller_addr_strobe_n_i,
  input  wire logic global_write_n_i,
  input  wire logic chip_select_primary_n_i,
  input  wire logic output_enable_n_i,
  input  wire logic sleep_request_i,
  input  wire logic dq_oe_o,
  input  wire logic wr_fifo_ready_o,
  input  wire logic asleep_o
);
  // Enable history, so a read is judged only once the synced enable is low.
  logic [2:0] oe_hist;
  always_ff @(posedge sys_clk_i) begin
    oe_hist <= {oe_hist[1:0], output_enable_n_i};
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Selected processor strobe while awake with the enable settled low.
  sequence rd_go;
    !processor_addr_strobe_n_i && !chip_select_primary_n_i && !asleep_o && oe_hist == 3'h0;
  endsequence
  a_read_drive: assert property (rd_go ##1 !output_enable_n_i [*2] |-> dq_oe_o)
    else $error("Read data not driven two edges after the strobe");
  a_write_quiet: assert property (!controller_addr_strobe_n_i && processor_addr_strobe_n_i
    && !global_write_n_i && !chip_select_primary_n_i && !asleep_o |=> !dq_oe_o)
    else $error("Drivers on after a sampled write");
  a_oe_off: assert property (output_enable_n_i [*4] |-> !dq_oe_o)
    else $error("Drivers on with the output enable high");
  a_sleep_enter: assert property (sleep_request_i [*5] |-> asleep_o)
    else $error("Power down not entered in time");
  a_sleep_quiet: assert property (asleep_o |-> !dq_oe_o)
    else $error("Drivers on while asleep");
  a_wake_hold: assert property ($fell(sleep_request_i) && asleep_o |-> asleep_o [*3])
    else $error("Woke before the wake-up time");
  a_wake_bound: assert property (asleep_o ##1 !sleep_request_i [*7] |-> !asleep_o)
    else $error("Still asleep long after the request fell");
  a_blocked_strobe: assert property (!processor_addr_strobe_n_i && chip_select_primary_n_i
    && controller_addr_strobe_n_i && !dq_oe_o ##1 !dq_oe_o |=> !dq_oe_o)
    else $error("Blocked strobe started a read");
  a_reset_quiet: assert property ($fell(srst_i) |-> !dq_oe_o && !asleep_o)
    else $error("Outputs active right after reset");
  a_fifo_room: assert property (!$past(srst_i) && !$past(srst_i, 2) |-> wr_fifo_ready_o)
    else $error("Write buffer refused while drained every cycle");
  // Main scenarios reached by the bench.
  c_read: cover property (rd_go ##2 dq_oe_o);
  c_write: cover property (!controller_addr_strobe_n_i && !global_write_n_i);
  c_sleep: cover property ($fell(asleep_o));
endmodule
bind pbs_core pbs_core_monitor MON (.sys_clk_i, .srst_i, .processor_addr_strobe_n_i,
  .controller_addr_strobe_n_i, .global_write_n_i, .chip_select_primary_n_i,
  .output_enable_n_i, .sleep_request_i, .dq_oe_o, .wr_fifo_ready_o, .asleep_o);

// *** sim/pbs_host.sv ***
// Processor-side model that drives the core's control and data pins.
`timescale 1ns/100ps
module pbs_host (
  input  wire logic        sys_clk_i,
  input  wire logic [35:0] dq_o_i
);
  // Control pins, idle between bursts except adv_n, left low after a read; secondary selects always active.
  logic [16:0] addr  = 17'h00000;
  logic        ps_n  = 1'b1, cs_n = 1'b1, adv_n = 1'b1, gw_n = 1'b1, bw_n = 1'b1;
  logic [3:0]  we_n  = 4'hF;
  logic        cs1_n = 1'b0, cs2 = 1'b1, cs2_n = 1'b0;
  logic        oe_n  = 1'b0, burst_order_select = 1'b0, zz = 1'b0;
  logic [35:0] dq    = 36'h0;
  // Write burst from the controller strobe with drivers kept off.
  task automatic wr(input logic [16:0] a, input logic [35:0] d [4], input logic glob,
                    input logic [3:0] lanes_n);
    @(posedge sys_clk_i);
    addr <= a; cs_n <= 1'b0; ps_n <= 1'b1; oe_n <= 1'b1;
    gw_n <= ~glob; bw_n <= 1'b0; we_n <= lanes_n; dq <= d[0];
    for (int i = 1; i < 4; i++) begin
      @(posedge sys_clk_i);
      cs_n <= 1'b1; adv_n <= 1'b0; dq <= d[i];
    end
    @(posedge sys_clk_i);
    gw_n <= 1'b1; bw_n <= 1'b1; we_n <= 4'hF; adv_n <= 1'b1; oe_n <= 1'b0;
    dq <= ~d[3]; // Released data shows no stale value.
    repeat (3) @(posedge sys_clk_i);
  endtask
  // Read burst from the processor strobe; st inserts one wait state.
  task automatic rd(input logic [16:0] a, input logic st, output logic [35:0] q [4]);
    @(posedge sys_clk_i);
    addr <= a; ps_n <= 1'b0; adv_n <= 1'b0; we_n <= 4'h0; bw_n <= 1'b0;
    @(posedge sys_clk_i);
    ps_n <= 1'b1; we_n <= 4'hF; bw_n <= 1'b1; addr <= ~a;
    for (int i = 0; i < 5 + st; i++) begin
      @(posedge sys_clk_i);
      adv_n <= (st && i == 0) || i == 2 + st;
      @(negedge sys_clk_i);
      if (i > 0) q[i - 1 - (st && i > 2)] = dq_o_i;
    end
  endtask
endmodule

// *** sim/test_pbs_core.sv ***
// Self-checking bench for the burst SRAM core.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module test_pbs_core;
  logic        sys_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic [35:0] dq_o;
  logic        dq_oe_o, wr_fifo_ready_o, asleep_o;
  int          error_cnt = 0, checks_done = 0;
  logic [35:0] mem [logic [16:0]]; // Expected array contents.
  logic [35:0] d [4], q [4];
  // One row: start address, order, global write, lane writes.
  typedef struct {logic [16:0] a; logic burst_order_select, glob; logic [3:0] lanes_n;} pbs_row_t;
  pbs_row_t rows [6] = '{'{17'h00000, 1'b0, 1'b1, 4'hF}, '{17'h00001, 1'b0, 1'b0, 4'hE},
    '{17'h1FFFE, 1'b1, 1'b1, 4'hF}, '{17'h1FFFD, 1'b1, 1'b0, 4'h3},
    '{17'h00002, 1'b1, 1'b0, 4'h0}, '{17'h00003, 1'b0, 1'b0, 4'hF}};
  always #12.5 sys_clk_i = ~sys_clk_i;
  pbs_host HOST (.sys_clk_i(sys_clk_i), .dq_o_i(dq_o));
  pbs_core DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(HOST.addr),
    .processor_addr_strobe_n_i(HOST.ps_n), .controller_addr_strobe_n_i(HOST.cs_n),
    .burst_advance_n_i(HOST.adv_n), .global_write_n_i(HOST.gw_n),
    .byte_write_enable_n_i(HOST.bw_n), .lane_a_write_n_i(HOST.we_n[0]),
    .lane_b_write_n_i(HOST.we_n[1]), .lane_c_write_n_i(HOST.we_n[2]),
    .lane_d_write_n_i(HOST.we_n[3]), .chip_select_primary_n_i(HOST.cs1_n),
    .chip_select_secondary_i(HOST.cs2), .chip_select_secondary_n_i(HOST.cs2_n),
    .output_enable_n_i(HOST.oe_n), .burst_order_select_i(HOST.burst_order_select),
    .sleep_request_i(HOST.zz), .dq_i(HOST.dq), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .wr_fifo_ready_o(wr_fifo_ready_o), .asleep_o(asleep_o));
  // Address of beat i: linear or interleaved low bits, upper bits fixed.
  function automatic logic [16:0] beat(input logic [16:0] a, input logic burst_order_select, input int i);
    beat = {a[16:2], burst_order_select ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)};
  endfunction
  // Distinct nine-bit value per lane, row and beat, parity bit included.
  function automatic logic [35:0] pat(input int r, input int i);
    for (int l = 0; l < 4; l++) pat[l*9 +: 9] = {2'(l), 3'(r), 2'(i), 2'h2};
  endfunction
  // Read a burst and compare every beat with the expected array.
  task automatic rd_chk(input logic [16:0] a, input logic burst_order_select, input logic st);
    HOST.rd(a, st, q);
    for (int i = 0; i < 4; i++) `CHK("read beat", mem[beat(a, burst_order_select, i)], q[i])
  endtask
  // Print the counts and the verdict, then stop.
  task automatic close_out();
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog sized well above the expected run.
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    error_cnt++;
    close_out();
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK("reset drive", 1'b0, dq_oe_o)
    `CHK("reset sleep", 1'b0, asleep_o)
    `CHK("fifo ready", 1'b1, wr_fifo_ready_o)
    foreach (rows[r]) begin
      HOST.burst_order_select <= rows[r].burst_order_select;
      repeat (3) @(posedge sys_clk_i);
      for (int i = 0; i < 4; i++) d[i] = pat(r, i);
      HOST.wr(rows[r].a, d, rows[r].glob, rows[r].lanes_n);
      for (int i = 0; i < 4; i++)
        for (int l = 0; l < 4; l++)
          if (rows[r].glob || !rows[r].lanes_n[l])
            mem[beat(rows[r].a, rows[r].burst_order_select, i)][l*9 +: 9] = d[i][l*9 +: 9];
      rd_chk(rows[r].a, rows[r].burst_order_select, 1'(r));
    end
    // Deselect, let the drivers fall, then strobe with the primary select high.
    @(posedge sys_clk_i);
    HOST.cs1_n <= 1'b1; HOST.cs_n <= 1'b0;
    @(posedge sys_clk_i);
    HOST.cs_n <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK("deselect drive", 1'b0, dq_oe_o)
    @(posedge sys_clk_i);
    HOST.ps_n <= 1'b0;
    @(posedge sys_clk_i);
    HOST.cs1_n <= 1'b0; HOST.ps_n <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK("blocked drive", 1'b0, dq_oe_o)
    // Sleep, wake, and confirm the contents survived.
    @(posedge sys_clk_i);
    HOST.zz <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK("asleep", 1'b1, asleep_o)
    @(posedge sys_clk_i);
    HOST.zz <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK("waking", 1'b1, asleep_o)
    for (int k = 0; k < 10 && asleep_o !== 1'b0; k++) @(negedge sys_clk_i);
    `CHK("awake", 1'b0, asleep_o)
    repeat (2) @(posedge sys_clk_i);
    rd_chk(17'h00000, HOST.burst_order_select, 1'b0);
    close_out();
  end
endmodule
